// file: include/dcl_defines.svh
`ifndef DCL_DEFINES_SVH
`define DCL_DEFINES_SVH

// ****************************************************************
// Register indexes (byte address = 4 * index)
// ****************************************************************
`define DCL_IDX_FSEL 0
`define DCL_IDX_CFG 1
`define DCL_IDX_CNT 2
`define DCL_IDX_LEN 3
`define DCL_IDX_OVL 4
`define DCL_IDX_HOT 5
`define DCL_IDX_PIDU 6
`define DCL_IDX_PIDL 7
`define DCL_IDX_ADTT 8
`define DCL_IDX_ADTH 9
`define DCL_IDX_UVS 10
`define DCL_IDX_PFE 11
`define DCL_IDX_PFD 12
`define DCL_IDX_RRT 13
`define DCL_IDX_ZSF 14
`define DCL_IDX_FDTT 15
`define DCL_IDX_FDTH 16
`define DCL_IDX_PT0 17
`define DCL_IDX_PT1 18
`define DCL_IDX_OCL 19
`define DCL_IDX_OCD 20
`define DCL_IDX_STAT 21
`define DCL_NUM_RW 21

// ****************************************************************
// Field positions
// ****************************************************************
`define DCL_CFG_NEG 0
`define DCL_CFG_PULSE 2
`define DCL_CFG_SW 4
`define DCL_FSEL_STRIDE 8

// ****************************************************************
// Reset values
// ****************************************************************
`define DCL_PULSE_RST 32'h017d7840
`define DCL_HOT_RST 32'h0000005a

// ****************************************************************
// Function codes
// ****************************************************************
`define DCL_FN_COUNT 7'h0f
`define DCL_FN_LENGTH 7'h10
`define DCL_FN_OVERLOAD 7'h11
`define DCL_FN_OVERHEAT 7'h12
`define DCL_FN_PID_HIGH 7'h13
`define DCL_FN_PID_LOW 7'h14
`define DCL_FN_ANALOG_LEVEL_DETECT_ONE 7'h15
`define DCL_FN_ANALOG_LEVEL_DETECT_TWO 7'h16
`define DCL_FN_UNDERVOLT 7'h18
`define DCL_FN_RUN_TIME 7'h1a
`define DCL_FN_ZERO_SPEED 7'h1b
`define DCL_FN_OFF_LOAD 7'h26
`define DCL_FN_SOFTWARE 7'h2f
`define DCL_FN_BRAKE 7'h43
`define DCL_FN_CUTOFF 7'h44
`define DCL_FN_FREQ_DETECT_ONE_LOW 7'h45
`define DCL_FN_FREQ_DETECT_TWO_LOW 7'h46
`define DCL_FN_FREQ_DETECT_ONE_LOW_NJ 7'h47
`define DCL_FN_FREQ_DETECT_TWO_LOW_NJ 7'h48
`define DCL_FN_OVERCURRENT 7'h49

// ****************************************************************
// Timing and margins
// ****************************************************************
`define DCL_CLK_KHZ 100000
`define DCL_LEVEL_PULSE_MS 100
`define DCL_LEVEL_PULSE_CYCLES (`DCL_LEVEL_PULSE_MS * `DCL_CLK_KHZ)
`define DCL_HEAT_SET_MARGIN 10
`define DCL_HEAT_CLR_MARGIN 15

`endif

// file: include/dcl_pkg.sv
package dcl_pkg;

  typedef logic [6:0] dcl_func_type;

  typedef enum logic [1:0] {
    UV_NORMAL,
    UV_LOW,
    UV_RECOVER
  } dcl_uv_state_type;

endpackage : dcl_pkg

// file: hdl/dcl_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none

module dcl_pulse_timer #(
  parameter int CW = 32
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic kill_i,
  input wire logic [CW-1:0] width_i,
  output logic active_o
);

  logic [CW-1:0] cnt_q;

  // A start restarts the pulse; a zero width still gives one cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (kill_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= (width_i == '0) ? CW'(1) : width_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  assign active_o = (cnt_q != '0);

endmodule : dcl_pulse_timer

`default_nettype wire

// file: hdl/dcl_output_cond.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_defines.svh"

// What this block does
// - Code 15: valid while pulse count at or above count threshold.
// - Code 16: valid while converted length at or above set length.
// - Code 17: valid while motor current at or above overload coefficient.
// - Code 18: set at hot spot minus 10, clear below minus 15.
// - Code 19: valid when running and PID feedback at or above upper.
// - Code 20: valid when running and PID feedback at or below lower.
// - Codes 21/22: analog set at threshold, clear at threshold minus hysteresis.
// - Code 24: set at stall level, clear after end level held delay.
// - Code 26: valid once regular running time is reached.
// - Code 38: valid while the drive is off-load.
// - Code 47: output follows its software control bit.
// - Code 68: valid while material cutoff is detected.
// - Codes 69/70: pulse when frequency drops below detect minus hysteresis.
// - Codes 71/72: as 69/70 but suppressed in jog.
// - Code 73: valid after overcurrent persists for the detection duration.
// - Positive logic drives active when valid; negative logic inverts.
// - Level type follows status; pulse type emits one pulse on valid.
module dcl_output_cond #(
  parameter int W = 16,
  parameter int CW = 32,
  parameter logic [CW-1:0] LEVEL_PULSE_CYCLES = `DCL_LEVEL_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [W-1:0] pulse_count_value_i,
  input wire logic [W-1:0] length_value_i,
  input wire logic [W-1:0] motor_current_i,
  input wire logic [W-1:0] temperature_i,
  input wire logic [W-1:0] pid_feedback_value_i,
  input wire logic [W-1:0] analog_in_one_i,
  input wire logic [W-1:0] analog_in_two_i,
  input wire logic [W-1:0] dc_bus_voltage_i,
  input wire logic [W-1:0] run_time_i,
  input wire logic [W-1:0] output_frequency_value_i,
  input wire logic [W-1:0] output_current_i,
  input wire logic running_i,
  input wire logic jog_i,
  input wire logic off_load_i,
  input wire logic brake_engaged_i,
  input wire logic material_cutoff_i,
  output logic open_collector_output_o,
  output logic relay_output_o
);

  // ****************************************************************
  // APB slave and register file
  // ****************************************************************
  logic [31:0] regs_q [0:`DCL_NUM_RW-1];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_val;
  logic [31:0] status_word;
  logic [5:0] idx;
  logic setup;
  logic wr_en;

  assign idx = paddr_i[7:2];
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_q & pwrite_i;

  always_comb begin
    rd_val = 32'h0;
    if (idx < 6'(`DCL_NUM_RW)) begin
      rd_val = regs_q[idx[4:0]];
    end else if (idx == 6'(`DCL_IDX_STAT)) begin
      rd_val = status_word;
    end
  end

  // The answer is prepared in the setup cycle so every bus output is a flop.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & (idx > 6'(`DCL_IDX_STAT));
      if (setup) begin
        prdata_q <= pwrite_i ? 32'h0 : rd_val;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `DCL_NUM_RW; i++) begin
        regs_q[i] <= 32'h0;
      end
      regs_q[`DCL_IDX_HOT] <= `DCL_HOT_RST;
      regs_q[`DCL_IDX_PT0] <= `DCL_PULSE_RST;
      regs_q[`DCL_IDX_PT1] <= `DCL_PULSE_RST;
    end else if (wr_en && idx < 6'(`DCL_NUM_RW)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_i[b]) begin
          regs_q[idx[4:0]][8*b +: 8] <= pwdata_i[8*b +: 8];
        end
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // ****************************************************************
  // Shared conditions
  // ****************************************************************
  logic [W:0] temp_set;
  logic [W:0] temp_clr;
  logic [W:0] hot_w;
  logic overheat_q;
  logic [1:0] adt_q;
  logic [1:0] fdt_cond_q;
  logic [1:0] fdt_ev;
  logic [W-1:0] ain [0:1];
  dcl_pkg::dcl_uv_state_type uv_state_q;
  logic [CW-1:0] uv_cnt_q;
  logic uv_flag;
  logic [CW-1:0] oc_cnt_q;
  logic oc_over;
  logic oc_q;

  assign hot_w = {1'b0, regs_q[`DCL_IDX_HOT][W-1:0]};
  assign temp_set = {1'b0, temperature_i} + (W+1)'(`DCL_HEAT_SET_MARGIN);
  assign temp_clr = {1'b0, temperature_i} + (W+1)'(`DCL_HEAT_CLR_MARGIN);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overheat_q <= 1'b0;
    end else if (temp_set >= hot_w) begin
      overheat_q <= 1'b1;
    end else if (temp_clr < hot_w) begin
      overheat_q <= 1'b0;
    end
  end

  assign ain[0] = analog_in_one_i;
  assign ain[1] = analog_in_two_i;

  for (genvar k = 0; k < 2; k++) begin : g_det
    logic [W:0] a_thr;
    logic [W:0] a_low;
    logic [W:0] f_low;
    assign a_thr = {1'b0, regs_q[`DCL_IDX_ADTT][16*k +: W]};
    assign a_low = {1'b0, ain[k]} + {1'b0, regs_q[`DCL_IDX_ADTH][16*k +: W]};
    assign f_low = {1'b0, output_frequency_value_i}
                 + {1'b0, regs_q[`DCL_IDX_FDTH][16*k +: W]};

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        adt_q[k] <= 1'b0;
        fdt_cond_q[k] <= 1'b0;
      end else begin
        if ({1'b0, ain[k]} >= a_thr) begin
          adt_q[k] <= 1'b1;
        end else if (a_low <= a_thr) begin
          adt_q[k] <= 1'b0;
        end
        fdt_cond_q[k] <= f_low < {1'b0, regs_q[`DCL_IDX_FDTT][16*k +: W]};
      end
    end

    assign fdt_ev[k] = (f_low < {1'b0, regs_q[`DCL_IDX_FDTT][16*k +: W]})
                     & ~fdt_cond_q[k];
  end

  // Recovery restarts whenever the bus dips below the end level.
  // A bus at or below the stall level always wins over recovery.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uv_state_q <= dcl_pkg::UV_NORMAL;
      uv_cnt_q <= '0;
    end else begin
      case (uv_state_q)
        dcl_pkg::UV_NORMAL: begin
          if (dc_bus_voltage_i <= regs_q[`DCL_IDX_UVS][W-1:0]) begin
            uv_state_q <= dcl_pkg::UV_LOW;
          end
        end
        dcl_pkg::UV_LOW: begin
          uv_cnt_q <= '0;
          if (dc_bus_voltage_i >= regs_q[`DCL_IDX_PFE][W-1:0]
              && dc_bus_voltage_i > regs_q[`DCL_IDX_UVS][W-1:0]) begin
            uv_state_q <= dcl_pkg::UV_RECOVER;
          end
        end
        dcl_pkg::UV_RECOVER: begin
          if (dc_bus_voltage_i < regs_q[`DCL_IDX_PFE][W-1:0]
              || dc_bus_voltage_i <= regs_q[`DCL_IDX_UVS][W-1:0]) begin
            uv_state_q <= dcl_pkg::UV_LOW;
          end else if (uv_cnt_q >= regs_q[`DCL_IDX_PFD][CW-1:0]) begin
            uv_state_q <= dcl_pkg::UV_NORMAL;
          end else begin
            uv_cnt_q <= uv_cnt_q + CW'(1);
          end
        end
        default: begin
          uv_state_q <= dcl_pkg::UV_NORMAL;
        end
      endcase
    end
  end

  assign uv_flag = (uv_state_q != dcl_pkg::UV_NORMAL);
  assign oc_over = output_current_i > regs_q[`DCL_IDX_OCL][W-1:0];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oc_cnt_q <= '0;
      oc_q <= 1'b0;
    end else begin
      if (!oc_over) begin
        oc_cnt_q <= '0;
      end else if (oc_cnt_q < regs_q[`DCL_IDX_OCD][CW-1:0]) begin
        oc_cnt_q <= oc_cnt_q + CW'(1);
      end
      oc_q <= oc_over && (oc_cnt_q >= regs_q[`DCL_IDX_OCD][CW-1:0]);
    end
  end

  // ****************************************************************
  // Per-terminal status and output shaping
  // ****************************************************************
  logic [1:0] status_q;
  logic [1:0] prev_q;
  logic [1:0] pin_q;
  dcl_pkg::dcl_func_type func_a [0:1];

  for (genvar t = 0; t < 2; t++) begin : g_term
    dcl_pkg::dcl_func_type func;
    logic [CW-1:0] ptime;
    logic neg;
    logic ptype;
    logic fdt_start;
    logic fdt_kill;
    logic fdt_act;
    logic out_act;
    logic status_d;

    assign func = regs_q[`DCL_IDX_FSEL][`DCL_FSEL_STRIDE*t +: 7];
    assign func_a[t] = func;
    assign ptime = regs_q[`DCL_IDX_PT0 + t][CW-1:0];
    assign neg = regs_q[`DCL_IDX_CFG][`DCL_CFG_NEG + t];
    assign ptype = regs_q[`DCL_IDX_CFG][`DCL_CFG_PULSE + t];
    assign fdt_kill = jog_i && (func == `DCL_FN_FREQ_DETECT_ONE_LOW_NJ
                             || func == `DCL_FN_FREQ_DETECT_TWO_LOW_NJ);
    assign fdt_start = ~fdt_kill
      & ((fdt_ev[0] & (func == `DCL_FN_FREQ_DETECT_ONE_LOW
                    || func == `DCL_FN_FREQ_DETECT_ONE_LOW_NJ))
       | (fdt_ev[1] & (func == `DCL_FN_FREQ_DETECT_TWO_LOW
                    || func == `DCL_FN_FREQ_DETECT_TWO_LOW_NJ)));

    dcl_pulse_timer #(.CW(CW)) u_fdt_pulse (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(fdt_start),
      .kill_i(fdt_kill),
      .width_i(ptype ? ptime : LEVEL_PULSE_CYCLES),
      .active_o(fdt_act)
    );

    always_comb begin
      case (func)
        `DCL_FN_COUNT: status_d = pulse_count_value_i
                                  >= regs_q[`DCL_IDX_CNT][W-1:0];
        `DCL_FN_LENGTH: status_d = length_value_i
                                   >= regs_q[`DCL_IDX_LEN][W-1:0];
        `DCL_FN_OVERLOAD: status_d = motor_current_i
                                     >= regs_q[`DCL_IDX_OVL][W-1:0];
        `DCL_FN_OVERHEAT: status_d = overheat_q;
        `DCL_FN_PID_HIGH: status_d = running_i && pid_feedback_value_i
                                     >= regs_q[`DCL_IDX_PIDU][W-1:0];
        `DCL_FN_PID_LOW: status_d = running_i && pid_feedback_value_i
                                    <= regs_q[`DCL_IDX_PIDL][W-1:0];
        `DCL_FN_ANALOG_LEVEL_DETECT_ONE: status_d = adt_q[0];
        `DCL_FN_ANALOG_LEVEL_DETECT_TWO: status_d = adt_q[1];
        `DCL_FN_UNDERVOLT: status_d = uv_flag;
        `DCL_FN_RUN_TIME: status_d = run_time_i
                                     >= regs_q[`DCL_IDX_RRT][W-1:0];
        `DCL_FN_ZERO_SPEED: status_d = (running_i || jog_i)
          && output_frequency_value_i <= regs_q[`DCL_IDX_ZSF][W-1:0];
        `DCL_FN_OFF_LOAD: status_d = off_load_i;
        `DCL_FN_SOFTWARE: status_d =
          regs_q[`DCL_IDX_CFG][`DCL_CFG_SW + t];
        `DCL_FN_BRAKE: status_d = brake_engaged_i;
        `DCL_FN_CUTOFF: status_d = material_cutoff_i;
        `DCL_FN_FREQ_DETECT_ONE_LOW, `DCL_FN_FREQ_DETECT_TWO_LOW,
        `DCL_FN_FREQ_DETECT_ONE_LOW_NJ, `DCL_FN_FREQ_DETECT_TWO_LOW_NJ: status_d = fdt_act;
        `DCL_FN_OVERCURRENT: status_d = oc_q;
        default: status_d = 1'b0;
      endcase
    end

    // Level type holds the timer idle, so a later switch to pulse type
    // cannot show a pulse that was armed while in level type.
    dcl_pulse_timer #(.CW(CW)) u_out_pulse (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(ptype & status_q[t] & ~prev_q[t]),
      .kill_i(~ptype),
      .width_i(ptime),
      .active_o(out_act)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        status_q[t] <= 1'b0;
        prev_q[t] <= 1'b0;
        pin_q[t] <= 1'b0;
      end else begin
        status_q[t] <= status_d;
        prev_q[t] <= status_q[t];
        pin_q[t] <= (ptype ? out_act : status_q[t]) ^ neg;
      end
    end
  end

  assign status_word = {23'h0, oc_q, uv_flag, adt_q, overheat_q,
                        pin_q, status_q};
  assign open_collector_output_o = pin_q[0];
  assign relay_output_o = pin_q[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_rise_pulse;
    $rose(status_q[0]) ##0 g_term[0].ptype && !g_term[0].neg;
  endsequence

  a_count_reach: assert property (
    func_a[0] == `DCL_FN_COUNT && $stable(func_a[0])
    |=> status_q[0] == $past(pulse_count_value_i
                             >= regs_q[`DCL_IDX_CNT][W-1:0]))
    else $error("count status wrong");
  a_heat_hold: assert property (
    overheat_q && !(temp_clr < hot_w) |=> overheat_q)
    else $error("overheat cleared inside hysteresis");
  a_adt_set: assert property (
    {1'b0, analog_in_one_i} >= g_det[0].a_thr |=> adt_q[0])
    else $error("analog detect not set");
  a_uv_set: assert property (
    dc_bus_voltage_i <= regs_q[`DCL_IDX_UVS][W-1:0] |=> ##1 uv_flag)
    else $error("undervoltage not flagged");
  a_oc_qualified: assert property (
    $rose(oc_q) |-> $past(oc_over) && $past(oc_cnt_q)
                    >= $past(regs_q[`DCL_IDX_OCD][CW-1:0]))
    else $error("overcurrent flagged early");
  a_sw_follow: assert property (
    func_a[0] == `DCL_FN_SOFTWARE ##1 func_a[0] == `DCL_FN_SOFTWARE
    |-> status_q[0] == $past(regs_q[`DCL_IDX_CFG][`DCL_CFG_SW]))
    else $error("software bit not followed");
  a_reserved_off: assert property (
    func_a[0] >= 7'h1c && func_a[0] <= 7'h25 |=> !status_q[0])
    else $error("reserved code gave valid");
  a_level_polarity: assert property (
    !g_term[0].ptype |=> pin_q[0] == ($past(status_q[0])
                                     ^ $past(g_term[0].neg)))
    else $error("level output polarity wrong");
  a_pulse_start: assert property (
    s_rise_pulse |=> ##1 pin_q[0])
    else $error("single pulse not emitted");
  a_jog_mask: assert property (
    jog_i && func_a[0] == `DCL_FN_FREQ_DETECT_ONE_LOW_NJ |=> !g_term[0].fdt_act)
    else $error("pulse not suppressed in jog");

endmodule : dcl_output_cond

`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcl_defines.svh"

module tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] v [0:10];
  logic [2:0] f = 3'h0;
  logic running = 1'b0;
  logic jog = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic oc_pin;
  logic relay_pin;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic err_q[$];
  int fails = 0;
  int total_checks = 0;
  int seed = 86765;
  int i;
  int j;
  logic [15:0] thr;
  logic [6:0] cd [0:6];
  int rg [0:6];
  int vi [0:6];
  bit le [0:6];

  dcl_output_cond #(.LEVEL_PULSE_CYCLES(32'h00000014)) u_dcl_output_cond (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pulse_count_value_i(v[0]),
    .length_value_i(v[1]), .motor_current_i(v[2]), .temperature_i(v[3]),
    .pid_feedback_value_i(v[4]), .analog_in_one_i(v[5]),
    .analog_in_two_i(v[6]), .dc_bus_voltage_i(v[7]), .run_time_i(v[8]),
    .output_frequency_value_i(v[9]), .output_current_i(v[10]),
    .running_i(running), .jog_i(jog), .off_load_i(f[0]),
    .brake_engaged_i(f[1]), .material_cutoff_i(f[2]),
    .open_collector_output_o(oc_pin), .relay_output_o(relay_pin)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic apb(input logic wr, input int idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= 8'(idx * 4);
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(negedge clk_i);
    while (pready_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    if (n >= 20) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input int idx, input logic [31:0] e,
                    input logic [31:0] m, input logic er);
    exp_q.push_back(e);
    msk_q.push_back(m);
    err_q.push_back(er);
    apb(1'b0, idx, 32'h0);
  endtask : rd

  task automatic st(input logic [31:0] e, input logic [31:0] m);
    repeat (4) @(posedge clk_i);
    rd(`DCL_IDX_STAT, e, m, 1'b0);
  endtask : st

  task automatic setfn(input logic [6:0] code);
    wr(`DCL_IDX_FSEL, {17'h0, `DCL_FN_SOFTWARE, 1'b0, code});
  endtask : setfn

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      fails++;
      $display("BAD %0t read data %h expected %h", $time, got, e);
    end
  endtask : cmp_data

  task automatic cmp_err(input logic got, input logic e);
    total_checks++;
    if (got !== e) begin
      fails++;
      $display("BAD %0t error response %b expected %b", $time, got, e);
    end
  endtask : cmp_err

  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] e);
    total_checks++;
    if (got !== e) begin
      fails++;
      $display("BAD %0t pins %b expected %b", $time, got, e);
    end
  endtask : cmp_pin

  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Bus answers are looked at mid-cycle, where they stand settled.
  always @(negedge clk_i) begin
    if (psel && penable && pready_o === 1'b1 && !pwrite) begin
      if (exp_q.size() > 0) begin
        cmp_data(prdata_o & msk_q[0], exp_q[0]);
        cmp_err(pslverr_o, err_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
        void'(err_q.pop_front());
      end
    end
  end

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    for (i = 0; i < 11; i++) v[i] = 16'h0;
    cd = '{`DCL_FN_COUNT, `DCL_FN_LENGTH, `DCL_FN_OVERLOAD, `DCL_FN_PID_HIGH,
           `DCL_FN_RUN_TIME, `DCL_FN_PID_LOW, `DCL_FN_ZERO_SPEED};
    rg = '{`DCL_IDX_CNT, `DCL_IDX_LEN, `DCL_IDX_OVL, `DCL_IDX_PIDU,
           `DCL_IDX_RRT, `DCL_IDX_PIDL, `DCL_IDX_ZSF};
    vi = '{0, 1, 2, 4, 8, 4, 9};
    le = '{0, 0, 0, 0, 0, 1, 1};
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`DCL_IDX_HOT, `DCL_HOT_RST, 32'hffffffff, 1'b0);
    rd(`DCL_IDX_PT1, `DCL_PULSE_RST, 32'hffffffff, 1'b0);
    rd(22, 32'h0, 32'hffffffff, 1'b1);
    running <= 1'b1;
    for (i = 0; i < 7; i++) begin
      thr = 16'h0100 + 16'($random(seed) & 32'h3fff);
      wr(rg[i], {16'h0, thr});
      setfn(cd[i]);
      v[vi[i]] <= thr;
      st(32'h1, 32'h1);
      v[vi[i]] <= le[i] ? thr + 16'h1 : thr - 16'h1;
      st(32'h0, 32'h1);
    end
    setfn(`DCL_FN_PID_HIGH);
    v[4] <= 16'hffff;
    running <= 1'b0;
    st(32'h0, 32'h1);
    running <= 1'b1;
    for (i = 0; i < 3; i++) begin
      setfn(7'h26 + 7'(i == 1) * 7'h1d + 7'(i == 2) * 7'h1e);
      f[i] <= 1'b1;
      st(32'h1, 32'h1);
      f[i] <= 1'b0;
      st(32'h0, 32'h1);
    end
    f <= 3'h7;
    setfn(7'h1e);
    st(32'h0, 32'h1);
    f <= 3'h0;
    setfn(`DCL_FN_OVERHEAT);
    for (j = 0; j < 6; j++) begin
      v[3] <= 16'(j == 0 ? 80 : j == 1 ? 76 : j == 2 ? 75 : j == 3 ? 74 :
                  j == 4 ? 79 : 80);
      st(32'(j != 3 && j != 4), 32'h1);
    end
    wr(`DCL_IDX_ADTT, {16'd1000, 16'd1000});
    wr(`DCL_IDX_ADTH, {16'd100, 16'd100});
    for (i = 0; i < 2; i++) begin
      setfn(i == 0 ? `DCL_FN_ANALOG_LEVEL_DETECT_ONE : `DCL_FN_ANALOG_LEVEL_DETECT_TWO);
      for (j = 0; j < 4; j++) begin
        v[5 + i] <= 16'(j == 0 ? 1000 : j == 1 ? 950 : j == 2 ? 900 : 999);
        st(32'(j < 2), 32'h1);
      end
    end
    wr(`DCL_IDX_UVS, 32'd300);
    wr(`DCL_IDX_PFE, 32'd400);
    wr(`DCL_IDX_PFD, 32'd5);
    setfn(`DCL_FN_UNDERVOLT);
    v[7] <= 16'd300;
    st(32'h1, 32'h1);
    v[7] <= 16'd400;
    rd(`DCL_IDX_STAT, 32'h1, 32'h1, 1'b0);
    repeat (8) @(posedge clk_i);
    st(32'h0, 32'h1);
    wr(`DCL_IDX_OCL, 32'd500);
    wr(`DCL_IDX_OCD, 32'd4);
    setfn(`DCL_FN_OVERCURRENT);
    v[10] <= 16'd501;
    rd(`DCL_IDX_STAT, 32'h0, 32'h1, 1'b0);
    st(32'h1, 32'h1);
    v[10] <= 16'd500;
    st(32'h0, 32'h1);
    wr(`DCL_IDX_FDTT, {16'd1000, 16'd1000});
    wr(`DCL_IDX_FDTH, {16'd100, 16'd100});
    for (i = 0; i < 4; i++) begin
      v[9] <= 16'd2000;
      jog <= i > 1;
      setfn(7'h45 + 7'(i));
      st(32'h0, 32'h1);
      v[9] <= 16'd850;
      st(32'(i < 2), 32'h1);
      repeat (24) @(posedge clk_i);
      st(32'h0, 32'h1);
    end
    jog <= 1'b0;
    setfn(`DCL_FN_SOFTWARE);
    wr(`DCL_IDX_CFG, 32'h10);
    st(32'h5, 32'hf);
    @(negedge clk_i);
    cmp_pin({relay_pin, oc_pin}, 2'b01);
    wr(`DCL_IDX_STAT, 32'h0);
    wr(`DCL_IDX_CFG, 32'h11);
    st(32'h1, 32'h5);
    wr(`DCL_IDX_CFG, 32'h01);
    st(32'h4, 32'h5);
    wr(`DCL_IDX_CFG, 32'h20);
    st(32'ha, 32'hf);
    @(negedge clk_i);
    cmp_pin({relay_pin, oc_pin}, 2'b10);
    wr(`DCL_IDX_PT0, 32'd10);
    wr(`DCL_IDX_CFG, 32'h04);
    st(32'h0, 32'h5);
    wr(`DCL_IDX_CFG, 32'h14);
    st(32'h5, 32'h5);
    repeat (16) @(posedge clk_i);
    st(32'h1, 32'h5);
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
